/* File: rtl/ipf_irq_unit.v */
// Interrupt flag, priority and external interrupt unit of the core.
// Assumes the core samples o_irq_req at instruction boundaries and pulses
// i_irq_ack when it takes the vector given on o_irq_id.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ipf_irq_defs.vh"

module ipf_irq_unit (
  input wire i_clk_sys,            // Core clock, 250 MHz
  input wire i_reset_n,            // Synchronous reset, active low
  input wire [7:0] i_addr,         // Register offset
  input wire [7:0] i_wdata,        // Write data
  input wire i_wr,                 // Write strobe
  input wire i_rd,                 // Read strobe
  output wire [7:0] o_rdata,       // Read data, cycle after i_rd
  input wire [1:0] i_ext_pin_n,    // External pins, active low
  input wire i_timer3_req,         // Timer 3 request
  input wire i_timer2_req,         // Timer 2 request
  input wire i_radio_req,          // Radio request
  input wire i_converter_done_flag, // Converter source flag
  input wire i_converter_irq_enable, // Converter local enable
  input wire i_cipher_done_flag,   // Cipher source flag
  input wire i_cipher_irq_enable,  // Cipher local enable
  input wire i_flash_debug_req,    // Flash/debug request
  input wire i_clock_alarm_req,    // Real-time clock request
  input wire [3:0] i_periph_req,   // Timer0, timer1, serial0, serial1 levels
  input wire i_instr_end,          // Instruction finished
  input wire i_irq_ack,            // Core takes the vector
  input wire i_reti,               // Return from interrupt done
  input wire i_idle_mode,          // Core is idle
  input wire i_power_down,         // Core is powered down
  output wire o_irq_req,           // Request to the core
  output wire [3:0] o_irq_id,      // Natural number of winner
  output wire [1:0] o_irq_level,   // Level of winner
  output wire o_idle_wake          // Wake the core from idle
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [3:0] ext_flag_hi_reg;
  reg [3:0] ext_flag_hi_next;
  reg [6:0] base_prio_reg;
  reg [4:0] ext_prio_reg;
  reg [7:0] base_en_reg;
  reg [4:0] ext_en_reg;
  reg fd_keep_reg;
  reg fd_en_reg;
  reg fd_flag_reg;
  reg alarm_flag_reg;
  reg [1:0] trig_reg;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg [2:0] in_svc_reg;
  reg [2:0] in_svc_next;
  reg holdoff_reg;
  reg req_reg;
  reg [3:0] id_reg;
  reg [1:0] lvl_reg;
  reg wake_reg;

  wire [1:0] ext_flag;
  wire [1:0] ext_active;
  wire [1:0] ext_ack;
  wire [1:0] ext_sw_val;
  wire wr_exf;
  wire wr_tc;
  wire wr_fd;
  wire ctrl_wr;
  wire conv_set;
  wire global_en;

  assign wr_exf = i_wr && (i_addr == `IPF_OFS_EXT_FLAG);
  assign wr_tc = i_wr && (i_addr == `IPF_OFS_TIMER_CTRL);
  assign wr_fd = i_wr && (i_addr == `IPF_OFS_FD_CTRL);
  assign ctrl_wr = i_wr && ((i_addr == `IPF_OFS_BASE_EN) || (i_addr == `IPF_OFS_EXT_EN) ||
                            (i_addr == `IPF_OFS_BASE_PRIO) || (i_addr == `IPF_OFS_EXT_PRIO));
  assign global_en = base_en_reg[`IPF_EN_GLOBAL];
  assign conv_set = (i_converter_done_flag & i_converter_irq_enable) |
                    (i_cipher_done_flag & i_cipher_irq_enable);

  // ****************************************************************
  // Extended flags
  // ****************************************************************
  // Hardware set wins over a software clear in the same cycle.
  always @* begin
    ext_flag_hi_next = wr_exf ? i_wdata[7:4] : ext_flag_hi_reg;
    if (i_timer3_req) begin
      ext_flag_hi_next[`IPF_EXF_TIMER3 - 4] = 1'b1;
    end
    if (conv_set) begin
      ext_flag_hi_next[`IPF_EXF_CONV - 4] = 1'b1;
    end
    if (i_timer2_req) begin
      ext_flag_hi_next[`IPF_EXF_TIMER2 - 4] = 1'b1;
    end
    if (i_radio_req) begin
      ext_flag_hi_next[`IPF_EXF_RADIO - 4] = 1'b1;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ext_flag_hi_reg <= 4'h0;
      base_prio_reg <= `IPF_RST_SEVEN;
      ext_prio_reg <= `IPF_RST_FIVE;
      base_en_reg <= `IPF_RST_BYTE;
      ext_en_reg <= `IPF_RST_FIVE;
      fd_keep_reg <= 1'b0;
      fd_en_reg <= 1'b0;
      fd_flag_reg <= 1'b0;
      alarm_flag_reg <= 1'b0;
      trig_reg <= 2'b00;
    end else begin
      ext_flag_hi_reg <= ext_flag_hi_next;
      if (i_wr && (i_addr == `IPF_OFS_BASE_PRIO)) begin
        base_prio_reg <= i_wdata[6:0];
      end
      if (i_wr && (i_addr == `IPF_OFS_EXT_PRIO)) begin
        ext_prio_reg <= i_wdata[4:0];
      end
      if (i_wr && (i_addr == `IPF_OFS_BASE_EN)) begin
        base_en_reg <= i_wdata;
      end
      if (i_wr && (i_addr == `IPF_OFS_EXT_EN)) begin
        ext_en_reg <= i_wdata[4:0];
      end
      if (wr_fd) begin
        fd_keep_reg <= i_wdata[`IPF_FD_KEEP];
        fd_en_reg <= i_wdata[`IPF_FD_ENABLE];
      end
      fd_flag_reg <= (wr_fd ? i_wdata[`IPF_FD_FLAG] : fd_flag_reg) | i_flash_debug_req;
      alarm_flag_reg <= (wr_fd ? i_wdata[`IPF_FD_ALARM] : alarm_flag_reg) | i_clock_alarm_req;
      if (wr_tc) begin
        trig_reg <= {i_wdata[`IPF_TC_TRIG_B], i_wdata[`IPF_TC_TRIG_A]};
      end
    end
  end

  // ****************************************************************
  // External pins
  // ****************************************************************
  assign ext_sw_val = {i_wdata[`IPF_TC_EXT1], i_wdata[`IPF_TC_EXT0]};
  assign ext_ack[0] = i_irq_ack && (id_reg == 4'd0);
  assign ext_ack[1] = i_irq_ack && (id_reg == 4'd2);

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pin
      ipf_ext_pin u_pin (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_pin_n(i_ext_pin_n[p]),
        .i_edge_mode(trig_reg[p]),
        .i_ack(ext_ack[p]),
        .i_sw_wr(wr_tc),
        .i_sw_val(ext_sw_val[p]),
        .o_flag(ext_flag[p]),
        .o_active(ext_active[p])
      );
    end
  endgenerate

  // ****************************************************************
  // Per-source level
  // ****************************************************************
  wire [11:0] src_flag;
  wire [11:0] src_en;
  wire [11:0] src_prio;
  wire [23:0] src_lvl;

  assign src_flag = {alarm_flag_reg, ext_flag_hi_reg[3], ext_flag_hi_reg[2], fd_flag_reg,
                     ext_flag_hi_reg[0], i_periph_req[3], ext_flag_hi_reg[1], i_periph_req[2],
                     i_periph_req[1], ext_flag[1], i_periph_req[0], ext_flag[0]};
  assign src_en = {ext_en_reg[4], ext_en_reg[3], ext_en_reg[2], fd_en_reg, ext_en_reg[0],
                   base_en_reg[6], ext_en_reg[1], base_en_reg[4], base_en_reg[3],
                   base_en_reg[2], base_en_reg[1], base_en_reg[0]};
  assign src_prio = {ext_prio_reg[4], ext_prio_reg[3], ext_prio_reg[2], 1'b0, ext_prio_reg[0],
                     base_prio_reg[6], ext_prio_reg[1], base_prio_reg[4], base_prio_reg[3],
                     base_prio_reg[2], base_prio_reg[1], base_prio_reg[0]};

  genvar s;
  generate
    for (s = 0; s < `IPF_NSRC; s = s + 1) begin : g_src
      wire pend;
      if (s == `IPF_SRC_FLASH) begin : g_fd
        assign pend = src_flag[s] & src_en[s];
        assign src_lvl[2*s +: 2] = pend ? `IPF_LVL_TOP : `IPF_LVL_NONE;
      end else begin : g_std
        assign pend = src_flag[s] & src_en[s] & global_en;
        assign src_lvl[2*s +: 2] = !pend ? `IPF_LVL_NONE :
                                   (src_prio[s] ? `IPF_LVL_HIGH : `IPF_LVL_LOW);
      end
    end
  endgenerate

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  reg [1:0] best_lvl;
  reg [3:0] best_id;
  reg [1:0] cur_lvl;
  integer k;

  // Scanning downward with >= lets the lowest number win a tie.
  always @* begin
    best_lvl = `IPF_LVL_NONE;
    best_id = `IPF_ID_NONE;
    for (k = `IPF_NSRC - 1; k >= 0; k = k - 1) begin
      if ((src_lvl[2*k +: 2] != `IPF_LVL_NONE) && (src_lvl[2*k +: 2] >= best_lvl)) begin
        best_lvl = src_lvl[2*k +: 2];
        best_id = k[3:0];
      end
    end
  end

  always @* begin
    if (in_svc_reg[2]) begin
      cur_lvl = `IPF_LVL_TOP;
    end else if (in_svc_reg[1]) begin
      cur_lvl = `IPF_LVL_HIGH;
    end else if (in_svc_reg[0]) begin
      cur_lvl = `IPF_LVL_LOW;
    end else begin
      cur_lvl = `IPF_LVL_NONE;
    end
  end

  // A return closes the most recent, hence highest, level in service.
  always @* begin
    in_svc_next = in_svc_reg;
    if (i_reti) begin
      if (in_svc_reg[2]) begin
        in_svc_next[2] = 1'b0;
      end else if (in_svc_reg[1]) begin
        in_svc_next[1] = 1'b0;
      end else begin
        in_svc_next[0] = 1'b0;
      end
    end
    if (i_irq_ack && (lvl_reg != `IPF_LVL_NONE)) begin
      in_svc_next[lvl_reg - 2'd1] = 1'b1;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      in_svc_reg <= 3'b000;
      holdoff_reg <= 1'b0;
      req_reg <= 1'b0;
      id_reg <= `IPF_ID_NONE;
      lvl_reg <= `IPF_LVL_NONE;
      wake_reg <= 1'b0;
    end else begin
      in_svc_reg <= in_svc_next;
      if (i_reti || ctrl_wr) begin
        holdoff_reg <= 1'b1;
      end else if (i_instr_end) begin
        holdoff_reg <= 1'b0;
      end
      // Dropped for one cycle after an ack so a stale winner is not offered twice.
      req_reg <= (best_lvl > cur_lvl) && !i_irq_ack;
      id_reg <= best_id;
      lvl_reg <= best_lvl;
      wake_reg <= i_idle_mode && !i_power_down && global_en &&
                  |(ext_active & {base_en_reg[2], base_en_reg[0]});
    end
  end

  // The core itself only samples at instruction end, so it never cuts one short.
  assign o_irq_req = req_reg && !holdoff_reg;
  assign o_irq_id = id_reg;
  assign o_irq_level = lvl_reg;
  assign o_idle_wake = wake_reg;

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @* begin
    case (i_addr)
      `IPF_OFS_EXT_FLAG: rdata_next = {ext_flag_hi_reg, `IPF_EXF_FIXED};
      `IPF_OFS_BASE_PRIO: rdata_next = {1'b1, base_prio_reg};
      `IPF_OFS_EXT_PRIO: rdata_next = {`IPF_ONES3, ext_prio_reg};
      `IPF_OFS_BASE_EN: rdata_next = base_en_reg;
      `IPF_OFS_EXT_EN: rdata_next = {`IPF_ONES3, ext_en_reg};
      `IPF_OFS_FD_CTRL: rdata_next = {fd_keep_reg, 1'b1, fd_en_reg, fd_flag_reg,
                                      alarm_flag_reg, 3'b000};
      `IPF_OFS_TIMER_CTRL: rdata_next = {4'h0, ext_flag[1], trig_reg[1], ext_flag[0],
                                         trig_reg[0]};
      default: rdata_next = `IPF_RST_BYTE;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rdata_reg <= `IPF_RST_BYTE;
    end else if (i_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `IPF_RST_BYTE;
    end
  end

  assign o_rdata = rdata_reg;

endmodule // ipf_irq_unit

`default_nettype wire

/* File: rtl/ipf_irq_defs.vh */
// Constants for the interrupt flag, priority and external interrupt unit.
// Assumes an 8-bit register port with byte offsets and a 250 MHz core clock.
`ifndef IPF_IRQ_DEFS_VH
`define IPF_IRQ_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define IPF_OFS_TIMER_CTRL 8'h88
`define IPF_OFS_EXT_FLAG 8'h91
`define IPF_OFS_BASE_EN 8'ha8
`define IPF_OFS_BASE_PRIO 8'hb8
`define IPF_OFS_FD_CTRL 8'hd8
`define IPF_OFS_EXT_EN 8'he8
`define IPF_OFS_EXT_PRIO 8'hf8

// ****************************************************************
// Field positions
// ****************************************************************
`define IPF_EXF_TIMER3 7
`define IPF_EXF_CONV 6
`define IPF_EXF_TIMER2 5
`define IPF_EXF_RADIO 4
`define IPF_EN_GLOBAL 7
`define IPF_FD_KEEP 7
`define IPF_FD_ENABLE 5
`define IPF_FD_FLAG 4
`define IPF_FD_ALARM 3
`define IPF_TC_TRIG_A 0
`define IPF_TC_EXT0 1
`define IPF_TC_TRIG_B 2
`define IPF_TC_EXT1 3

// ****************************************************************
// Reset values and fixed read bits
// ****************************************************************
`define IPF_RST_BYTE 8'h00
`define IPF_RST_FIVE 5'h00
`define IPF_RST_SEVEN 7'h00
`define IPF_EXF_FIXED 4'h8
`define IPF_ONES3 3'h7

// ****************************************************************
// Levels and sources
// ****************************************************************
`define IPF_LVL_NONE 2'd0
`define IPF_LVL_LOW 2'd1
`define IPF_LVL_HIGH 2'd2
`define IPF_LVL_TOP 2'd3
`define IPF_NSRC 12
`define IPF_SRC_FLASH 8
`define IPF_ID_NONE 4'h0

// ****************************************************************
// Timing
// ****************************************************************
// Shortest pin pulse, in core clock cycles, that always makes a request.
`define IPF_EXT_MIN_PULSE_CYC 8

`endif

/* File: rtl/ipf_ext_pin.v */
// One external interrupt pin: synchroniser, edge or level detection, flag.
// Assumes an active-low pin asynchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none

module ipf_ext_pin (
  input wire i_clk_sys,   // Core clock
  input wire i_reset_n,   // Synchronous reset, active low
  input wire i_pin_n,     // Raw pin, active low
  input wire i_edge_mode, // 1 falling edge, 0 level
  input wire i_ack,       // Core took this source
  input wire i_sw_wr,     // Software writes the flag, edge mode only
  input wire i_sw_val,    // Value written
  output wire o_flag,     // Request flag
  output wire o_active    // Pin active after synchronisation
);

  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  reg flag_reg;
  reg flag_next;
  wire fall;

  // ****************************************************************
  // Synchroniser and detection
  // ****************************************************************
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin_n;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      flag_reg <= flag_next;
    end
  end

  // Three cycles of latency leave ample margin inside an 8-cycle pulse.
  assign fall = prev_reg & ~sync2_reg;

  always @* begin
    if (!i_edge_mode) begin
      flag_next = ~sync2_reg;
    end else begin
      flag_next = i_sw_wr ? i_sw_val : (flag_reg & ~i_ack);
      if (fall) begin
        flag_next = 1'b1;
      end
    end
  end

  assign o_flag = flag_reg;
  assign o_active = ~sync2_reg;

endmodule // ipf_ext_pin

`default_nettype wire

/* File: testbench/ipf_irq_unit_assertions.sv */
// Port-level checks for the interrupt flag, priority and pin unit.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module ipf_irq_checker (
  input wire logic i_clk_sys, // Core clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic [7:0] i_addr, // Register offset
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [7:0] o_rdata, // Read data
  input wire logic i_timer3_req, // Timer 3 request
  input wire logic i_timer2_req, // Timer 2 request
  input wire logic i_radio_req, // Radio request
  input wire logic i_irq_ack, // Core takes vector
  input wire logic i_reti, // Return done
  input wire logic i_power_down, // Power-down mode
  input wire logic o_irq_req, // Request to core
  input wire logic [3:0] o_irq_id, // Winner number
  input wire logic [1:0] o_irq_level, // Winner level
  input wire logic o_idle_wake // Idle wake
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // Shadow of the global enable, needed to judge which winners may show.
  logic ge_reg;
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) ge_reg <= 1'b0;
    else if (i_wr && i_addr == 8'ha8) ge_reg <= i_wdata[7];
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_flag_fixed; $past(i_rd) && $past(i_addr) == 8'h91 |-> o_rdata[3:0] == 4'h8;
  endproperty
  a_flag_fixed: assert property (p_flag_fixed) else $error("flag low nibble wrong");
  property p_base_top; $past(i_rd) && $past(i_addr) == 8'hb8 |-> o_rdata[7]; endproperty
  a_base_top: assert property (p_base_top) else $error("base priority bit 7 low");
  property p_ext_top; $past(i_rd) && $past(i_addr) == 8'hf8 |-> o_rdata[7:5] == 3'h7;
  endproperty
  a_ext_top: assert property (p_ext_top) else $error("extended priority top bits");
  sequence s_flag_rd; $past(i_rd) && $past(i_addr) == 8'h91; endsequence
  property p_t3_flag; s_flag_rd and $past(i_timer3_req, 2) |-> o_rdata[7]; endproperty
  a_t3_flag: assert property (p_t3_flag) else $error("timer 3 flag not set");
  property p_t2_flag; s_flag_rd and $past(i_timer2_req, 2) |-> o_rdata[5]; endproperty
  a_t2_flag: assert property (p_t2_flag) else $error("timer 2 flag not set");
  property p_rf_flag; s_flag_rd and $past(i_radio_req, 2) |-> o_rdata[4]; endproperty
  a_rf_flag: assert property (p_rf_flag) else $error("radio flag not set");
  property p_top_flash; o_irq_req && o_irq_level == 2'd3 |-> o_irq_id == 4'd8; endproperty
  a_top_flash: assert property (p_top_flash) else $error("top level not flash");
  property p_ack_drop; i_irq_ack |=> !o_irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_holdoff; i_reti || (i_wr && i_addr == 8'ha8) |=> !o_irq_req; endproperty
  a_holdoff: assert property (p_holdoff) else $error("request not held off");
  property p_gate; o_irq_req && !ge_reg |-> o_irq_id == 4'd8; endproperty
  a_gate: assert property (p_gate) else $error("request with global off");
  property p_pd_wake; i_power_down |=> !o_idle_wake; endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("wake in power-down");
  c_high: cover property (i_irq_ack && o_irq_level == 2'd2);
  c_flash: cover property (i_irq_ack && o_irq_id == 4'd8);
  c_wake: cover property (o_idle_wake);
endmodule // ipf_irq_checker

bind ipf_irq_unit ipf_irq_checker u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_timer3_req(i_timer3_req), .i_timer2_req(i_timer2_req), .i_radio_req(i_radio_req),
  .i_irq_ack(i_irq_ack), .i_reti(i_reti), .i_power_down(i_power_down),
  .o_irq_req(o_irq_req), .o_irq_id(o_irq_id), .o_irq_level(o_irq_level),
  .o_idle_wake(o_idle_wake));
`default_nettype wire

/* File: testbench/ipf_core_model.sv */
// Behavioural core: instruction boundaries, vector take and return.
// Assumes the bench gates vector taking so it can stall the core.
`timescale 1ns/1ns
`default_nettype none

module ipf_core_model (
  input wire logic i_clk_sys, // Core clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_take, // Bench allows vector taking
  input wire logic i_ret, // Bench requests a return
  input wire logic i_irq_req, // Request from the unit
  output logic o_instr_end, // Instruction boundary
  output logic o_irq_ack, // Vector taken
  output logic o_reti // Return done
);
  logic [1:0] cnt_reg;
  // Every third cycle ends an instruction; vectors are taken only there.
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_reg <= 2'd0;
      o_instr_end <= 1'b0;
      o_irq_ack <= 1'b0;
      o_reti <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 2'd2) ? 2'd0 : cnt_reg + 2'd1;
      o_instr_end <= (cnt_reg == 2'd2);
      o_irq_ack <= i_take && i_irq_req && (cnt_reg == 2'd2) && !o_irq_ack;
      o_reti <= i_ret;
    end
  end
endmodule // ipf_core_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the interrupt flag, priority and pin unit.
// Assumes the core model and the checker are compiled beside it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("mismatch time %0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic i_clk_sys, i_reset_n, i_wr, i_rd, take, ret, conv_done, conv_en, flash_req;
  logic i_idle_mode, i_power_down, instr_end, irq_ack, reti, rd_d;
  logic o_irq_req, o_idle_wake;
  logic [7:0] i_addr, i_wdata, o_rdata, got, exp_v;
  logic [3:0] src, o_irq_id;
  logic [1:0] i_ext_pin_n, o_irq_level;
  logic [7:0] q[$];
  int fails, cmp_count;
  int unsigned r;

  ipf_irq_unit dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_pin_n(i_ext_pin_n),
    .i_timer3_req(src[0]), .i_timer2_req(src[2]), .i_radio_req(src[3]),
    .i_converter_done_flag(conv_done), .i_converter_irq_enable(conv_en),
    .i_cipher_done_flag(src[1]), .i_cipher_irq_enable(1'b1), .i_flash_debug_req(flash_req),
    .i_clock_alarm_req(1'b0), .i_periph_req(4'h0), .i_instr_end(instr_end),
    .i_irq_ack(irq_ack), .i_reti(reti), .i_idle_mode(i_idle_mode),
    .i_power_down(i_power_down), .o_irq_req(o_irq_req), .o_irq_id(o_irq_id),
    .o_irq_level(o_irq_level), .o_idle_wake(o_idle_wake));

  ipf_core_model core (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_take(take),
    .i_ret(ret), .i_irq_req(o_irq_req), .o_instr_end(instr_end), .o_irq_ack(irq_ack),
    .o_reti(reti));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  // An unexpected result pops nothing and compares against unknown, so it fails.
  always @(posedge i_clk_sys) begin
    if (rd_d || irq_ack) begin
      exp_v = (q.size() != 0) ? q.pop_front() : 8'hxx;
      got = rd_d ? o_rdata : {2'b00, o_irq_level, o_irq_id};
      `CHK(got, exp_v)
    end
    rd_d <= i_rd;
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_empty();
    for (int n = 0; n < 400 && q.size() != 0; n++) @(posedge i_clk_sys);
    if (q.size() != 0) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic take_one(input logic [7:0] e);
    q.push_back(e);
    @(posedge i_clk_sys);
    take <= 1'b1;
    wait_empty();
    take <= 1'b0;
  endtask
  task automatic do_reset();
    i_reset_n <= 1'b0;
    cyc(20);
    i_reset_n <= 1'b1;
    cyc(2);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {i_wr, i_rd, take, ret, conv_done, conv_en, flash_req} = 7'h00;
    {i_idle_mode, i_power_down, i_addr, i_wdata, src} = 22'h0;
    i_ext_pin_n = 2'b11;
    i_reset_n = 1'b0;
    r = $urandom(32'h244a_df32);
    do_reset();
    rd(8'h91, 8'h08);
    rd(8'hb8, 8'h80);
    rd(8'hf8, 8'he0);
    rd(8'h55, 8'h00);
    wr(8'hb8, 8'h7f);
    rd(8'hb8, 8'hff);
    r = $urandom();
    wr(8'hf8, r[7:0]);
    rd(8'hf8, {3'h7, r[4:0]});
    wr(8'hf8, 8'h00);
    wr(8'hb8, 8'h00);
    // The request stands in the cycle before the read strobe, so the checker's
    // two-cycle look-back sees it while the flag is read.
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk_sys);
      src <= 4'h1 << k;
      rd(8'h91, 8'h08 | (8'h80 >> k));
      src <= 4'h0;
      wr(8'h91, 8'h00);
      rd(8'h91, 8'h08);
    end
    conv_done <= 1'b1;
    cyc(3);
    rd(8'h91, 8'h08);
    conv_en <= 1'b1;
    cyc(3);
    rd(8'h91, 8'h48);
    conv_done <= 1'b0;
    wr(8'h91, 8'hff);
    rd(8'h91, 8'hf8);
    // Low level ties go to the smallest natural number.
    wr(8'ha8, 8'h80);
    wr(8'he8, 8'h1f);
    cyc(8);
    take_one({2'b00, 2'd1, 4'd5});
    wr(8'hf8, 8'h08);
    cyc(8);
    take_one({2'b00, 2'd2, 4'd10});
    wr(8'hf8, 8'h0a);
    take <= 1'b1;
    cyc(40);
    q.push_back({2'b00, 2'd2, 4'd5});
    ret <= 1'b1;
    cyc(1);
    ret <= 1'b0;
    wait_empty();
    take <= 1'b0;
    wr(8'hd8, 8'h20);
    wr(8'ha8, 8'h00);
    flash_req <= 1'b1;
    cyc(1);
    flash_req <= 1'b0;
    cyc(6);
    take_one({2'b00, 2'd3, 4'd8});
    do_reset();
    rd(8'h91, 8'h08);
    // Edge pin pulse just over the minimum, then a held level pin.
    wr(8'h88, 8'h01);
    wr(8'ha8, 8'h85);
    cyc(4);
    i_ext_pin_n <= 2'b10;
    cyc($urandom_range(9, 12));
    i_ext_pin_n <= 2'b11;
    cyc(8);
    take_one({2'b00, 2'd1, 4'd0});
    ret <= 1'b1;
    cyc(1);
    ret <= 1'b0;
    cyc(6);
    i_ext_pin_n <= 2'b01;
    cyc(6);
    take_one({2'b00, 2'd1, 4'd2});
    i_idle_mode <= 1'b1;
    cyc(4);
    `CHK(o_idle_wake, 1'b1)
    i_power_down <= 1'b1;
    cyc(4);
    `CHK(o_idle_wake, 1'b0)
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
